// *** ptl_pkg.sv ***
// Package for the protocol type list responder: payload layout, codes, carrier types.
// Assumes one 100 MHz clock and 32-bit payload words streamed MSB byte first.
package ptl_pkg;

    // ------------------------------------------------------------
    // Payload codes and layout
    // ------------------------------------------------------------
    localparam logic [7:0] PTL_REQ_CODE = 8'h63;
    localparam logic [7:0] PTL_ACC_CODE = 8'h02;
    localparam logic [7:0] PTL_RJT_CODE = 8'h01;
    localparam logic [7:0] PTL_VENDOR_TYPE_MIN = 8'hE0;
    localparam logic [15:0] PTL_HDR_BYTES = 16'h0008;
    localparam logic [15:0] PTL_ENTRY_BYTES = 16'h0004;
    localparam int PTL_CODE_MSB = 31;
    localparam int PTL_CODE_LSB = 24;
    localparam int PTL_LEN_MSB = 15;
    localparam int PTL_LEN_LSB = 0;
    localparam int PTL_TOTAL_LSB = 16;
    localparam int PTL_INDEX_LSB = 0;
    localparam int PTL_QUAL_W = 24;
    localparam int PTL_FIFO_DEPTH = 32;
    localparam int PTL_MAX_ENTRIES = 16;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] data;
        logic last;
    } ptl_word_t;

    typedef struct packed {
        logic [7:0] protocol_type_code;
        logic [23:0] registered_org_identifier;
    } ptl_entry_t;

endpackage : ptl_pkg

// *** ptl_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; width and depth are parameters, depth a power of two.
module ptl_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;
    logic valid_reg, valid_next, room_reg, room_next;

    // Flags registered so both handshake outputs come straight from flops
    assign in_ready = room_reg;
    assign out_valid = valid_reg;
    assign out_data = mem[rd_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_next = wr_reg + (AW+1)'(push);
        rd_next = rd_reg + (AW+1)'(pop);
        valid_next = (wr_next != rd_next);
        room_next = (wr_next - rd_next) != (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_reg <= '0;
            rd_reg <= '0;
            valid_reg <= 1'b0;
            room_reg <= 1'b1;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            valid_reg <= valid_next;
            room_reg <= room_next;
        end
    end
endmodule : ptl_fifo

// *** ptl_responder.sv ***
// Responder for the protocol type list request: parses a two-word request,
// answers with an acceptance listing or a reject, through a 32-word FIFO.
// Assumes requests arrive as word streams; the sink applies back-pressure.

// How it works
// RQ1 - Requester puts max reply bytes in low half of request word 0.
// RQ2 - A zero max size means the reply length is unbounded.
// RQ3 - Requester puts starting index in low byte of request word 1.
// RQ4 - Supported protocols are indexed from zero to count minus one.
// RQ5 - Acceptance reply carries code 02h in top byte of word 0.
// RQ6 - A declined request is answered with a reject reply instead.
// RQ7 - Reply word 0 low half holds length eight plus four per entry.
// RQ8 - Reply word 1 byte one holds total supported protocol count.
// RQ9 - Requester may page forward by entries received when more remain.
// RQ10 - Reply word 1 last byte echoes the starting index requested.
// RQ11 - Each entry word holds type code on top, qualifier below.
// RQ12 - Types 00h to DFh carry a zero qualifier.
// RQ13 - Types E0h to FFh carry the defining organisation identifier.
// RQ14 - Requester only asks after port login has completed.
// RQ15 - With nonzero limit, entries are cut to fit the limit.
// RQ16 - Entries go out ascending from the index to end or limit.
module ptl_responder
    import ptl_pkg::*;
#(
    parameter int NUM_ENTRIES = ptl_pkg::PTL_MAX_ENTRIES,
    parameter int FIFO_DEPTH = ptl_pkg::PTL_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input ptl_pkg::ptl_word_t req_word,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] supported_count,
    input ptl_pkg::ptl_entry_t [NUM_ENTRIES-1:0] entry_table,
    input wire logic service_enable,
    output ptl_pkg::ptl_word_t rsp_word,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic busy
);
    import ptl_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] entry_word(input ptl_entry_t e);
        // Standard-range types must not leak a qualifier
        if (e.protocol_type_code >= PTL_VENDOR_TYPE_MIN) begin
            return {e.protocol_type_code, e.registered_org_identifier}; // RQ13
        end
        return {e.protocol_type_code, {PTL_QUAL_W{1'b0}}}; // RQ12
    endfunction : entry_word

    typedef enum {S_W0, S_W1, S_HDR0, S_HDR1, S_ENT, S_RJT} ptl_state_t;

    ptl_state_t state_reg, state_next;
    logic [15:0] max_reg, max_next;
    logic [7:0] idx_reg, idx_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [7:0] pos_reg, pos_next;
    logic [7:0] total_reg, total_next;
    logic ok_reg, ok_next;
    logic busy_reg, busy_next;
    logic ready_reg, ready_next;
    ptl_word_t f_in;
    logic f_valid, f_ready;
    logic [7:0] avail, fit, limit_cap;
    logic [15:0] room;
    logic [7:0] clamp_count;

    // ------------------------------------------------------------
    // Entry count: available from index, bounded by size limit
    // ------------------------------------------------------------
    always_comb begin
        clamp_count = (supported_count > 8'(NUM_ENTRIES)) ? 8'(NUM_ENTRIES)
                                                        : supported_count; // RQ4
        avail = (idx_reg < clamp_count) ? (clamp_count - idx_reg) : 8'h00; // RQ16
        room = (max_reg > PTL_HDR_BYTES) ? (max_reg - PTL_HDR_BYTES) : 16'h0000;
        limit_cap = (room[15:2] > 14'h00FF) ? 8'hFF : room[9:2];
        if (max_reg == 16'h0000) begin
            fit = avail; // RQ2
        end else begin
            fit = (avail < limit_cap) ? avail : limit_cap; // RQ15
        end
    end

    // ------------------------------------------------------------
    // Request parse and reply build
    // ------------------------------------------------------------
    assign req_ready = ready_reg;

    always_comb begin
        state_next = state_reg;
        max_next = max_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        pos_next = pos_reg;
        total_next = total_reg;
        ok_next = ok_reg;
        busy_next = (state_reg != S_W0);
        f_in = '0;
        f_valid = 1'b0;
        case (state_reg)
            S_W0: begin
                if (req_valid) begin
                    ok_next = service_enable
                        && req_word.data[PTL_CODE_MSB:PTL_CODE_LSB] == PTL_REQ_CODE;
                    max_next = req_word.data[PTL_LEN_MSB:PTL_LEN_LSB]; // RQ1
                    // Short request: reject without waiting for word 1
                    if (req_word.last) begin
                        ok_next = 1'b0;
                        state_next = S_RJT;
                    end else begin
                        state_next = S_W1;
                    end
                end
            end
            S_W1: begin
                if (req_valid) begin
                    idx_next = req_word.data[PTL_INDEX_LSB +: 8]; // RQ3
                    // Extra trailing words would be misparsed, so refuse
                    if (!req_word.last) begin
                        ok_next = 1'b0;
                    end
                    state_next = (ok_reg && req_word.last) ? S_HDR0 : S_RJT;
                end
            end
            S_HDR0: begin
                cnt_next = fit;
                pos_next = idx_reg;
                total_next = supported_count;
                f_valid = 1'b1;
                f_in.data = {PTL_ACC_CODE, 8'h00,
                    16'(PTL_HDR_BYTES + PTL_ENTRY_BYTES * 16'(fit))}; // RQ5 RQ7
                if (f_ready) begin
                    state_next = S_HDR1;
                end
            end
            S_HDR1: begin
                f_valid = 1'b1;
                f_in.data = {8'h00, total_reg, 8'h00, idx_reg}; // RQ8 RQ10
                f_in.last = (cnt_reg == 8'h00);
                if (f_ready) begin
                    state_next = (cnt_reg == 8'h00) ? S_W0 : S_ENT;
                end
            end
            S_ENT: begin
                f_valid = 1'b1;
                f_in.data = entry_word(entry_table[pos_reg[$clog2(NUM_ENTRIES)-1:0]]); // RQ11
                f_in.last = (cnt_reg == 8'h01);
                if (f_ready) begin
                    pos_next = pos_reg + 8'h01; // RQ16
                    cnt_next = cnt_reg - 8'h01;
                    if (cnt_reg == 8'h01) begin
                        state_next = S_W0;
                    end
                end
            end
            S_RJT: begin
                f_valid = 1'b1;
                f_in.data = {PTL_RJT_CODE, 24'h000000}; // RQ6
                f_in.last = 1'b1;
                if (f_ready) begin
                    state_next = S_W0;
                end
            end
            default: state_next = S_W0;
        endcase
        ready_next = (state_next == S_W0) || (state_next == S_W1);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_W0;
            max_reg <= 16'h0000;
            idx_reg <= 8'h00;
            cnt_reg <= 8'h00;
            pos_reg <= 8'h00;
            total_reg <= 8'h00;
            ok_reg <= 1'b0;
            busy_reg <= 1'b0;
            ready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            max_reg <= max_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            pos_reg <= pos_next;
            total_reg <= total_next;
            ok_reg <= ok_next;
            busy_reg <= busy_next;
            ready_reg <= ready_next;
        end
    end

    assign busy = busy_reg;

    // ------------------------------------------------------------
    // Output buffer; back-pressure stalls the builder
    // ------------------------------------------------------------
    ptl_word_t f_out;
    ptl_fifo #(.WIDTH($bits(ptl_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_data(f_in),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .out_data(f_out),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready)
    );
    assign rsp_word = f_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_acc_len;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_HDR0 && f_ready) |->
            f_in.data[1:0] == 2'b00 && f_in.data[15:0] >= 16'd8
            && (f_in.data[15:0] - 16'd8) <= {6'h00, avail, 2'b00};
    endproperty
    a_acc_len: assert property (p_acc_len) else $error("bad reply length"); // RQ7

    property p_acc_code;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_HDR0) |-> f_in.data[31:24] == 8'h02;
    endproperty
    a_acc_code: assert property (p_acc_code) else $error("bad accept code"); // RQ5

    property p_limit;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_HDR0 && max_reg >= 16'd8) |->
            (f_in.data[15:0] <= max_reg);
    endproperty
    a_limit: assert property (p_limit) else $error("reply exceeds limit"); // RQ15

    property p_qual_zero;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_ENT && f_in.data[31:24] < 8'hE0) |-> f_in.data[23:0] == 24'h0;
    endproperty
    a_qual_zero: assert property (p_qual_zero) else $error("qualifier not zero"); // RQ12

    property p_index_echo;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_HDR1) |-> f_in.data[7:0] == idx_reg && f_in.data[23:16] == total_reg;
    endproperty
    a_index_echo: assert property (p_index_echo) else $error("bad word 1"); // RQ10

    property p_ascend;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_ENT && f_ready && cnt_reg != 8'h01) |=>
            pos_reg == $past(pos_reg) + 8'h01;
    endproperty
    a_ascend: assert property (p_ascend) else $error("entries not ascending"); // RQ16

    property p_reject;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_W1 && req_valid && !ok_reg) |=> state_reg == S_RJT;
    endproperty
    a_reject: assert property (p_reject) else $error("missing reject"); // RQ6

    property p_unbounded;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == S_HDR0 && max_reg == 16'h0) |->
            f_in.data[15:0] == {6'h00, avail, 2'b00} + 16'd8;
    endproperty
    a_unbounded: assert property (p_unbounded) else $error("zero limit cut list"); // RQ2

    c_accept: cover property (@(posedge clk) disable iff (!rst_b) state_reg == S_HDR0 && f_ready);
    c_reject: cover property (@(posedge clk) disable iff (!rst_b) state_reg == S_RJT && f_ready);
    c_stall: cover property (@(posedge clk) disable iff (!rst_b) f_valid && !f_ready);
endmodule : ptl_responder

// *** ptl_sink_model.sv ***
// Far-side model: the port that receives the responder's reply words.
// Assumes the reply stream is valid/ready, both sampled on the rising clock.
module ptl_sink_model
    import ptl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input ptl_pkg::ptl_word_t rsp_word,
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire logic [1:0] mode
);
    import ptl_pkg::*;

    // ------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------
    // Mode 0 prompt, 1 one edge in four, 2 stalled
    ptl_word_t got[$];
    logic [1:0] phase_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_ready <= 1'b0;
            phase_reg <= 2'h0;
        end else begin
            if (rsp_valid && rsp_ready) begin
                got.push_back(rsp_word);
            end
            phase_reg <= phase_reg + 2'h1;
            rsp_ready <= (mode == 2'h0) || (mode == 2'h1 && phase_reg == 2'h2);
        end
    end
endmodule : ptl_sink_model

// *** testbench.sv ***
// Self-checking bench for the protocol type list responder.
// Assumes the far-side sink model and the design's own embedded assertions.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ptl_pkg::*;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic service_enable = 1'b0;
    logic [7:0] supported_count = 8'h00;
    logic [1:0] mode = 2'h0;
    ptl_word_t req_word = '0;
    ptl_entry_t [15:0] entry_table;
    ptl_word_t rsp_word;
    logic rsp_valid;
    logic rsp_ready;
    logic req_ready;
    logic busy;
    int bad_count = 0;
    int tests_run = 0;
    ptl_word_t exp_q[$];

    always #5 clk = ~clk;

    ptl_responder uut (.clk(clk), .rst_b(rst_b), .req_word(req_word), .req_valid(req_valid),
        .req_ready(req_ready), .supported_count(supported_count), .entry_table(entry_table),
        .service_enable(service_enable), .rsp_word(rsp_word), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .busy(busy));

    ptl_sink_model sink (.clk(clk), .rst_b(rst_b), .rsp_word(rsp_word), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .mode(mode));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk_word(input ptl_word_t g, input ptl_word_t e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t word got %h exp %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e, input string what);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t %s got %b", $time, what, g);
        end
    endtask : chk_bit

    // Ready is looked at on the falling edge, where it has settled
    task automatic put(input logic [31:0] d, input logic l);
        req_word <= '{d, l};
        req_valid <= 1'b1;
        forever begin
            @(negedge clk);
            if (req_ready === 1'b1) break;
        end
        @(posedge clk);
    endtask : put

    task automatic request(input logic [7:0] code, input logic [15:0] mx, input logic [7:0] ix);
        put({code, 8'h00, mx}, 1'b0);
        put({24'h000000, ix}, 1'b1);
        req_valid <= 1'b0;
        @(posedge clk);
    endtask : request

    task automatic expect_list(input logic [15:0] mx, input logic [7:0] ix);
        int n;
        ptl_entry_t e;
        n = (supported_count > ix) ? int'(supported_count - ix) : 0;
        if (mx != 16'h0000 && ((mx < 16'h0008) ? 0 : int'(mx - 16'h0008) / 4) < n) begin
            n = (mx < 16'h0008) ? 0 : int'(mx - 16'h0008) / 4;
        end
        exp_q.push_back({PTL_ACC_CODE, 8'h00, 16'(8 + 4 * n), 1'b0});
        exp_q.push_back({8'h00, supported_count, 8'h00, ix, n == 0});
        for (int k = 0; k < n; k++) begin
            e = entry_table[int'(ix) + k];
            exp_q.push_back({e.protocol_type_code, (e.protocol_type_code >= 8'hE0) ?
                e.registered_org_identifier : 24'h000000, k == n - 1});
        end
    endtask : expect_list

    task automatic collect(input string name);
        int w;
        w = 0;
        while (sink.got.size() < exp_q.size() && w < 3000) begin
            @(posedge clk);
            w++;
        end
        repeat (8) @(posedge clk);
        chk_bit(sink.got.size() == exp_q.size(), 1'b1, "reply word count");
        for (int i = 0; i < exp_q.size() && i < sink.got.size(); i++) begin
            chk_word(sink.got[i], exp_q[i]);
        end
        sink.got.delete();
        exp_q.delete();
        $display("%s done", name);
    endtask : collect

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_full();
        supported_count <= 8'h05;
        request(PTL_REQ_CODE, 16'h0000, 8'h00);
        expect_list(16'h0000, 8'h00);
        collect("full list");
        @(negedge clk);
        chk_bit(busy, 1'b0, "busy when idle");
        @(posedge clk);
    endtask : t_full

    task automatic t_page();
        mode <= 2'h1;
        request(PTL_REQ_CODE, 16'h0010, 8'h01);
        expect_list(16'h0010, 8'h01);
        request(PTL_REQ_CODE, 16'h0010, 8'h03);
        expect_list(16'h0010, 8'h03);
        request(PTL_REQ_CODE, 16'h000B, 8'h00);
        expect_list(16'h000B, 8'h00);
        request(PTL_REQ_CODE, 16'h0000, 8'h07);
        expect_list(16'h0000, 8'h07);
        collect("paged slow sink");
        mode <= 2'h0;
    endtask : t_page

    task automatic t_reject();
        service_enable <= 1'b0;
        request(PTL_REQ_CODE, 16'h0000, 8'h00);
        exp_q.push_back({PTL_RJT_CODE, 24'h000000, 1'b1});
        service_enable <= 1'b1;
        request(8'h64, 16'h0000, 8'h00);
        exp_q.push_back({PTL_RJT_CODE, 24'h000000, 1'b1});
        // Request cut short after its first word
        put({PTL_REQ_CODE, 8'h00, 16'h0000}, 1'b1);
        req_valid <= 1'b0;
        @(posedge clk);
        exp_q.push_back({PTL_RJT_CODE, 24'h000000, 1'b1});
        // Second word not marked as the last one
        put({PTL_REQ_CODE, 8'h00, 16'h0000}, 1'b0);
        put({24'h000000, 8'h00}, 1'b0);
        req_valid <= 1'b0;
        @(posedge clk);
        exp_q.push_back({PTL_RJT_CODE, 24'h000000, 1'b1});
        collect("reject");
    endtask : t_reject

    // Two full replies overrun the buffer, so the second must wait
    task automatic t_fifo_full();
        mode <= 2'h2;
        supported_count <= 8'h10;
        request(PTL_REQ_CODE, 16'h0000, 8'h00);
        expect_list(16'h0000, 8'h00);
        request(PTL_REQ_CODE, 16'h0000, 8'h00);
        expect_list(16'h0000, 8'h00);
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk_bit(req_ready, 1'b0, "ready with buffer full");
        chk_bit(rsp_valid, 1'b1, "valid while stalled");
        chk_bit(busy, 1'b1, "busy while stalled");
        mode <= 2'h0;
        collect("buffer fill and drain");
    endtask : t_fifo_full

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    initial begin
        for (int i = 0; i < 16; i++) begin
            // Both sides of the reserved/vendor boundary, nonzero org everywhere
            entry_table[i] = i[0] ? {8'(8'hDF + i), 24'(24'h123400 + i)} :
                {(i == 0) ? 8'hDF : 8'(8'h10 + i), 24'(24'hA5A500 + i)};
        end
        repeat (15) @(posedge clk);
        @(negedge clk);
        chk_bit(req_ready, 1'b1, "ready in reset");
        chk_bit(rsp_valid, 1'b0, "valid in reset");
        chk_bit(busy, 1'b0, "busy in reset");
        @(posedge clk);
        rst_b <= 1'b1;
        service_enable <= 1'b1;
        @(posedge clk);
        t_full();
        t_page();
        t_reject();
        t_fifo_full();
        end_sim();
    end

    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule : testbench
